// file: pkg/pol_defines.svh
`ifndef POL_DEFINES_SVH
`define POL_DEFINES_SVH
// Register indices; byte address is four times the index
`define POL_IDX_OUT0 4'h0
`define POL_IDX_OUT1 4'h1
`define POL_IDX_LVL0 4'h2
`define POL_IDX_LVL1 4'h3
`define POL_IDX_DIR0 4'h4
`define POL_IDX_DIR1 4'h5
`define POL_IDX_RCTL 4'h6
// Reset values
`define POL_RST_OUT0 8'hFF
`define POL_RST_OUT1 7'h7F
`define POL_RST_DIRN0 8'hFF
`define POL_RST_DIRN1 7'h7F
// Field positions
`define POL_RSTPIN_BIT 6
`define POL_RESET_PIN_DISABLE_BIT 0
`endif

// file: pkg/pol_pkg.sv
package pol_pkg;
   // Pad controls of one port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pu;
   } pol_pad0_t;
   typedef struct packed {
      logic [6:0] out;
      logic [6:0] oe_n;
      logic [6:0] pu;
   } pol_pad1_t;
   // Whole block state
   typedef struct packed {
      logic wait_r;
      logic [31:0] rdata;
      logic [7:0] out0;
      logic [6:0] out1;
      logic [7:0] dirn0;
      logic [6:0] dirn1;
      logic reset_pin_disable;
      logic [7:0] pu0;
      logic [6:0] pu1;
      logic rst_req;
   } pol_state_t;
endpackage : pol_pkg

// file: design/pol_port_regs.sv
`timescale 1ns/1ps
`include "pol_defines.svh"
module pol_port_regs
   import pol_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] p0_pin_in,
   input wire logic [6:0] p1_pin_in,
   output pol_pad0_t p0_pad,
   output pol_pad1_t p1_pad,
   output logic device_reset_req
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   pol_state_t s_q;
   pol_state_t s_d;
   logic [3:0] idx;
   logic req;
   logic commit;
   logic wr_lane;

   assign idx = avs_address[5:2];
   assign req = avs_read | avs_write;
   // Access completes on the second cycle of a request
   assign commit = req & ~s_q.wait_r;
   assign wr_lane = avs_write & commit & avs_byteenable[0];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_d = s_q;
      // Waitrequest drops for exactly one cycle per request
      s_d.wait_r = ~(req & s_q.wait_r);
      s_d.rdata = 32'h0000_0000;
      if (avs_read & s_q.wait_r)
      begin
         unique case (idx)
            `POL_IDX_OUT0: s_d.rdata[7:0] = s_q.out0;
            `POL_IDX_OUT1: s_d.rdata[6:0] = s_q.out1;
            // Live pins, no stored copy
            `POL_IDX_LVL0: s_d.rdata[7:0] = p0_pin_in;
            `POL_IDX_LVL1: s_d.rdata[6:0] = p1_pin_in;
            `POL_IDX_DIR0: s_d.rdata[7:0] = ~s_q.dirn0;
            `POL_IDX_DIR1: s_d.rdata[6:0] = ~s_q.dirn1;
            `POL_IDX_RCTL: s_d.rdata[`POL_RESET_PIN_DISABLE_BIT] = s_q.reset_pin_disable;
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      else if (avs_read & commit)
      begin
         s_d.rdata = s_q.rdata;
      end
      // Writes; level registers ignore them
      if (wr_lane)
      begin
         unique case (idx)
            `POL_IDX_OUT0: s_d.out0 = avs_writedata[7:0];
            `POL_IDX_OUT1: s_d.out1 = avs_writedata[6:0];
            `POL_IDX_DIR0: s_d.dirn0 = ~avs_writedata[7:0];
            `POL_IDX_DIR1: s_d.dirn1 = ~avs_writedata[6:0];
            `POL_IDX_RCTL: s_d.reset_pin_disable = avs_writedata[`POL_RESET_PIN_DISABLE_BIT];
            default: s_d.reset_pin_disable = s_q.reset_pin_disable;
         endcase
      end
      // Pull-up only on input pins whose latch bit is one
      s_d.pu0 = s_d.out0 & s_d.dirn0;
      s_d.pu1 = s_d.out1 & s_d.dirn1;
      // Reset pin: external low, or own driver pulling low
      s_d.rst_req = ~s_q.reset_pin_disable &
         (~p1_pin_in[`POL_RSTPIN_BIT] |
          (~s_q.dirn1[`POL_RSTPIN_BIT] &
           ~s_q.out1[`POL_RSTPIN_BIT]));
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // All reset forms land here; the device reset request
   // is fed back by the system to sys_rst
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.wait_r <= 1'b1;
         s_q.out0 <= `POL_RST_OUT0;
         s_q.out1 <= `POL_RST_OUT1;
         s_q.dirn0 <= `POL_RST_DIRN0;
         s_q.dirn1 <= `POL_RST_DIRN1;
         s_q.pu0 <= `POL_RST_OUT0;
         s_q.pu1 <= `POL_RST_OUT1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Driver released while a pin is an input
   assign p0_pad.out = s_q.out0;
   assign p0_pad.oe_n = s_q.dirn0;
   assign p0_pad.pu = s_q.pu0;
   assign p1_pad.out = s_q.out1;
   assign p1_pad.oe_n = s_q.dirn1;
   assign p1_pad.pu = s_q.pu1;
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wait_r;
   assign device_reset_req = s_q.rst_req;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_out0_reset_ones: assert property (
      $fell(sys_rst) |-> p0_pad.out == 8'hFF)
      else $error("port 0 latch not FF after reset");
   a_out1_reset_val: assert property (
      $fell(sys_rst) |-> p1_pad.out == 7'h7F)
      else $error("port 1 latch not 7F after reset");
   a_out0_write_lands: assert property (
      (wr_lane && idx == `POL_IDX_OUT0) |=>
      p0_pad.out == $past(avs_writedata[7:0]))
      else $error("port 0 write lost");
   a_out1_write_lands: assert property (
      (wr_lane && idx == `POL_IDX_OUT1) |=>
      p1_pad.out == $past(avs_writedata[6:0]))
      else $error("port 1 write lost");
   a_pullup_gate: assert property (
      p0_pad.pu == (p0_pad.out & p0_pad.oe_n))
      else $error("pull-up not latch and input");
   a_read_latch: assert property (
      (avs_read && s_q.wait_r && idx == `POL_IDX_OUT0)
      ##1 commit |-> avs_readdata == {24'h0, p0_pad.out})
      else $error("latch read mismatch");
   a_dir_keeps_latch: assert property (
      (wr_lane && idx == `POL_IDX_DIR1) |=>
      p1_pad.out == $past(p1_pad.out))
      else $error("direction write changed latch");
   a_bit7_zero: assert property (
      (avs_read && commit && idx == `POL_IDX_OUT1)
      |-> avs_readdata[31:7] == 25'h0)
      else $error("port 1 bit 7 not zero");
   a_reset_pin: assert property (
      (!s_q.reset_pin_disable && !p1_pin_in[`POL_RSTPIN_BIT])
      |=> device_reset_req)
      else $error("reset pin ignored");
   a_reset_disabled: assert property (
      s_q.reset_pin_disable |=> !device_reset_req)
      else $error("reset pin acted while disabled");
   a_self_reset: assert property (
      (!s_q.reset_pin_disable && !p1_pad.oe_n[6] && !p1_pad.out[6])
      |=> device_reset_req)
      else $error("self drive low gave no reset");
   a_level_live: assert property (
      (avs_read && s_q.wait_r && idx == `POL_IDX_LVL0)
      |=> avs_readdata[7:0] == $past(p0_pin_in))
      else $error("port 0 level not live");
   a_level1_live: assert property (
      (avs_read && s_q.wait_r && idx == `POL_IDX_LVL1)
      |=> avs_readdata == {25'h0, $past(p1_pin_in)})
      else $error("port 1 level not live");
   a_wait_one: assert property (
      (req && s_q.wait_r) |=> !avs_waitrequest ##1
      avs_waitrequest)
      else $error("waitrequest not one cycle low");

   // ----------------------------------------
   // Further checks
   // ----------------------------------------
   // Port 1 pull-up follows the same gate as port 0
   a_pullup1_gate: assert property (
      p1_pad.pu == (p1_pad.out & p1_pad.oe_n))
      else $error("port 1 pull-up not latch and input");
   // A driven pin must never also have its pull-up on, or the
   // pad would fight its own weak pull-up on a low output
   a_pu0_off_drive: assert property (
      (p0_pad.pu & ~p0_pad.oe_n) == 8'h00)
      else $error("port 0 pull-up on while driving");
   a_pu1_off_drive: assert property (
      (p1_pad.pu & ~p1_pad.oe_n) == 7'h00)
      else $error("port 1 pull-up on while driving");
   // Level registers hold no storage, so writes must not touch pads
   a_lvl0_no_write: assert property (
      (wr_lane && idx == `POL_IDX_LVL0) |=>
      (p0_pad == $past(p0_pad)) && (p1_pad == $past(p1_pad)))
      else $error("write to port 0 levels changed pads");
   a_lvl1_no_write: assert property (
      (wr_lane && idx == `POL_IDX_LVL1) |=>
      (p0_pad == $past(p0_pad)) && (p1_pad == $past(p1_pad)))
      else $error("write to port 1 levels changed pads");
   // Holes in the map read as zero; software may probe them freely
   a_unmapped_zero: assert property (
      (avs_read && s_q.wait_r && idx > `POL_IDX_RCTL) |=>
      avs_readdata == 32'h0000_0000)
      else $error("unmapped index read not zero");
   // Read data is cleared once the access ends, so a stale word
   // cannot be taken by a master that samples late
   a_rdata_idle: assert property (
      (!avs_read && s_q.wait_r) |=> avs_readdata == 32'h0000_0000)
      else $error("read data not cleared when idle");
   // Without a request the bus stays stalled
   a_wait_idle: assert property (
      (!req && s_q.wait_r) |=> avs_waitrequest)
      else $error("waitrequest dropped with no request");

   c_write_out0: cover property (wr_lane && idx == `POL_IDX_OUT0);
   c_read_lvl1: cover property (avs_read && commit &&
      idx == `POL_IDX_LVL1);
   c_self_reset: cover property (device_reset_req &&
      !p1_pad.oe_n[6]);
   c_back_to_back: cover property (commit ##1 (req && s_q.wait_r));
   c_dir_write: cover property (wr_lane && idx == `POL_IDX_DIR1);

endmodule : pol_port_regs

// file: bench/pol_board.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board model: levels the pads settle to
// ----------------------------------------
module pol_board
   import pol_pkg::*;
(
   input wire logic ref_clk,
   input pol_pad0_t p0_pad,
   input pol_pad1_t p1_pad,
   input wire logic [14:0] ext_en,
   input wire logic [14:0] ext_val,
   output logic [7:0] p0_pin_in,
   output logic [6:0] p1_pin_in
);
   logic [14:0] drv_n;
   logic [14:0] flt_q;
   // A floating pin wanders so a stale level can never pass
   always_ff @(posedge ref_clk)
      flt_q <= (flt_q === 15'h2AAA) ? 15'h5555 : 15'h2AAA;
   assign drv_n = {p1_pad.oe_n, p0_pad.oe_n};
   // Chip driver wins, then board drive, then pull-up, else float
   assign {p1_pin_in, p0_pin_in} = ~drv_n & {p1_pad.out, p0_pad.out}
      | drv_n & (ext_en & ext_val
      | ~ext_en & ({p1_pad.pu, p0_pad.pu} | flt_q));
endmodule : pol_board

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
   import pol_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] p0_pin_in;
   logic [6:0] p1_pin_in;
   pol_pad0_t p0_pad;
   pol_pad1_t p1_pad;
   logic device_reset_req;
   logic [14:0] ext_en = 15'h0000;
   logic [14:0] ext_val = 15'h0000;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   // ----------------------------------------
   // Clock, block and board
   // ----------------------------------------
   always #12.5 ref_clk = ~ref_clk;
   pol_port_regs uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .p0_pin_in(p0_pin_in),
      .p1_pin_in(p1_pin_in), .p0_pad(p0_pad), .p1_pad(p1_pad),
      .device_reset_req(device_reset_req));
   pol_board board (.ref_clk(ref_clk), .p0_pad(p0_pad), .p1_pad(p1_pad),
      .ext_en(ext_en), .ext_val(ext_val), .p0_pin_in(p0_pin_in),
      .p1_pin_in(p1_pin_in));
   // Cut a hang short; the whole run needs under a hundred cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   // Request held until waitrequest is seen low, then one idle edge.
   // Levels are looked at mid-cycle, where they are settled, so the
   // edge that launches waitrequest can never race the check.
   task automatic acc(input logic w, input logic [5:0] a,
      input logic [7:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= ~w;
      @(posedge ref_clk);
      @(negedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(negedge ref_clk);
      q = avs_readdata;
      // Edge at which waitrequest low is taken; release after it
      @(posedge ref_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : acc
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      acc(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask : rd
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
   endtask : do_reset
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_vals();
      rd(6'h00, 32'h000000FF);
      rd(6'h04, 32'h0000007F);
      chk({8'h00, p0_pad}, 32'h00FFFFFF);
      chk({11'h000, p1_pad}, 32'h001FFFFF);
      rd(6'h08, 32'h000000FF);
      rd(6'h1C, 32'h00000000);
   endtask : t_reset_vals
   task automatic t_latch();
      wr(6'h00, 8'h5A);
      rd(6'h00, 32'h0000005A);
      chk({24'h000000, p0_pad.pu}, 32'h0000005A);
      wr(6'h04, 8'hFF);
      rd(6'h04, 32'h0000007F);
   endtask : t_latch
   // Outputs follow the latch; turning back keeps the latch
   task automatic t_dir();
      wr(6'h10, 8'hFF);
      chk({16'h0000, p0_pad.out, p0_pad.oe_n}, 32'h00005A00);
      rd(6'h08, 32'h0000005A);
      wr(6'h10, 8'h00);
      rd(6'h00, 32'h0000005A);
      ext_en <= 15'h40FF;
      ext_val <= 15'h40A5;
      rd(6'h08, 32'h000000A5);
      wr(6'h04, 8'h15);
      wr(6'h14, 8'h3F);
      rd(6'h0C, 32'h00000055);
      chk({31'h00000000, device_reset_req}, 32'h00000000);
   endtask : t_dir
   // Own pin 1.6 driven low asks for reset until disabled
   task automatic t_rst_pin();
      wr(6'h14, 8'h7F);
      repeat (2) @(posedge ref_clk);
      chk({31'h00000000, device_reset_req}, 32'h00000001);
      wr(6'h18, 8'h01);
      repeat (2) @(posedge ref_clk);
      chk({31'h00000000, device_reset_req}, 32'h00000000);
      do_reset();
      rd(6'h00, 32'h000000FF);
      rd(6'h04, 32'h0000007F);
   endtask : t_rst_pin
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      do_reset();
      t_reset_vals();
      t_latch();
      t_dir();
      t_rst_pin();
      end_of_test();
   end
endmodule : testbench
